// ### design/array_mem.sv
/*
  Small logic array store with one write port and a registered read.
  Assumes writer and reader share one clock.
*/
`timescale 1ns/1ps
`default_nettype none
module array_mem #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic clk, // Clock
  input wire logic rst_n, // Async reset, low
  input wire logic we, // Write strobe
  input wire logic [AW-1:0] waddr, // Write address
  input wire logic [WIDTH-1:0] wdata, // Write data
  input wire logic [AW-1:0] raddr, // Read address
  output logic [WIDTH-1:0] rdata // Registered read data
);

  logic [WIDTH-1:0] mem_r [DEPTH];

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("array_mem: DEPTH must be a power of two");
  end

  always_ff @(posedge clk) begin
    if (we) begin
      mem_r[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= '0;
    end else begin
      rdata <= mem_r[raddr];
    end
  end

endmodule : array_mem
`default_nettype wire

// ### design/preload_pkg.sv
/*
  Constants, register map and shared types of the macrocell preload scan
  and security block. Assumes an APB slave with 32-bit data and byte
  addresses, and a single clock pclk at 40 MHz.
*/
// Function
// - Secured device blocks array programming and verify
// - Security cleared only by full bulk erase or by presetn
// - Holds a 64-bit user signature word
// - Signature readable whether secured or not
// - Signature never affects the logic function
// - Bulk erase clears array, architecture, security, signature
// - Preload only while high-voltage pin asserted
// - One chain stage per registered macrocell
// - Each shift clock rising edge shifts one bit
// - Data enters lowest pin, moves upward
// - Old register contents shift out serially
// - Readout ignores output enable conditions
// - Serial low means 0, high means 1
// - Register state appears inverted on output pins
package preload_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int NUM_CELLS = 8;
  localparam int SIG_BITS = 64;
  localparam int ARRAY_DEPTH = 16;
  localparam int WORD_BITS = 32;

  // ---------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_ARCH = 8'h08;
  localparam logic [7:0] OFS_SIG_LO = 8'h0c;
  localparam logic [7:0] OFS_SIG_HI = 8'h10;
  localparam logic [7:0] OFS_ARR_ADDR = 8'h14;
  localparam logic [7:0] OFS_ARR_DATA = 8'h18;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CTRL_ERASE_BIT = 0;
  localparam int CTRL_SECURE_BIT = 1;
  localparam int STAT_SECURED_BIT = 0;
  localparam int STAT_PRELOAD_BIT = 1;
  localparam int STAT_ERASING_BIT = 2;
  localparam int ARCH_REG_LSB = 0;
  localparam int ARCH_POL_LSB = 8;

  // Synchroniser lanes for pin inputs
  localparam int SY_MODE = 0;
  localparam int SY_SIN = 1;
  localparam int SY_SCLK = 2;
  localparam int SY_FCLK = 3;
  localparam int SY_OEN = 4;
  localparam int SY_LANES = 5;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [NUM_CELLS-1:0] REG_MASK_RST = 8'h00;
  localparam logic [NUM_CELLS-1:0] POL_RST = 8'h00;
  localparam logic [SIG_BITS-1:0] SIG_RST = 64'h0;
  localparam logic [NUM_CELLS-1:0] CELL_RST = 8'h00;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [NUM_CELLS-1:0] polarity;
    logic [NUM_CELLS-1:0] registered;
  } arch_s;

  typedef enum logic [1:0] {
    ER_IDLE = 2'b00,
    ER_WALK = 2'b01
  } erase_e;

endpackage : preload_pkg

// ### design/preload_security.sv
/*
  Macrocell register preload chain, security cell, user signature and
  bulk erase, with an APB register slave. Assumes all pins arrive
  asynchronous to pclk; the shift and function clocks are sampled, so
  their pulses must be well wider than two pclk periods.
*/
`timescale 1ns/1ps
`default_nettype none
module preload_security #(
  parameter int DEPTH = preload_pkg::ARRAY_DEPTH
) (
  input wire logic pclk, // APB clock, 40 MHz
  input wire logic presetn, // Async reset, low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic preload_mode_hv_pin, // Preload entry pin
  input wire logic serial_preload_in, // Serial data in
  input wire logic preload_shift_clock, // Shift clock pin
  input wire logic func_clock_pin, // Normal register clock pin
  input wire logic output_enable_n_pin, // Common output enable, low
  input wire logic [preload_pkg::NUM_CELLS-1:0] mc_logic_in, // Sum terms
  output logic serial_preload_out_o, // Open drain level, always 0
  output logic serial_preload_out_oe, // Open drain enable
  output logic [preload_pkg::NUM_CELLS-1:0] mc_pin_o, // Cell pin level
  output logic [preload_pkg::NUM_CELLS-1:0] mc_pin_oe // Cell pin enable
);

  localparam int N = preload_pkg::NUM_CELLS;
  localparam int AW = $clog2(DEPTH);
  localparam int W = preload_pkg::WORD_BITS;

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("preload_security: DEPTH must be a power of two");
  end

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [preload_pkg::SY_LANES-1:0] pins;
  logic [preload_pkg::SY_LANES-1:0] sync1_r;
  logic [preload_pkg::SY_LANES-1:0] sync2_r;
  logic [preload_pkg::SY_LANES-1:0] sync3_r;

  assign pins = {output_enable_n_pin, func_clock_pin, preload_shift_clock,
                 serial_preload_in, preload_mode_hv_pin};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
    end else begin
      sync1_r <= pins;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  wire preload_active = sync2_r[preload_pkg::SY_MODE];
  wire sclk_rise = sync2_r[preload_pkg::SY_SCLK] &
                   ~sync3_r[preload_pkg::SY_SCLK];
  wire fclk_rise = sync2_r[preload_pkg::SY_FCLK] &
                   ~sync3_r[preload_pkg::SY_FCLK];
  wire shift_edge = preload_active & sclk_rise;
  wire func_edge = ~preload_active & fclk_rise;
  wire sin_bit = sync2_r[preload_pkg::SY_SIN];
  wire oe_pin_n = sync2_r[preload_pkg::SY_OEN];

  // ---------------------------------------------------------------
  // Programmable state
  // ---------------------------------------------------------------
  preload_pkg::arch_s arch_r;
  preload_pkg::arch_s arch_nxt;
  logic [preload_pkg::SIG_BITS-1:0] sig_r;
  logic [preload_pkg::SIG_BITS-1:0] sig_nxt;
  logic secured_r;
  logic secured_nxt;
  logic [AW-1:0] arr_addr_r;
  logic [AW-1:0] arr_addr_nxt;
  preload_pkg::erase_e er_state_r;
  preload_pkg::erase_e er_state_nxt;
  logic [AW-1:0] er_addr_r;
  logic [AW-1:0] er_addr_nxt;

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  wire access = psel & penable;
  wire take = access & ~pready; // Answer cycle being prepared
  wire wr_fire = access & pwrite & pready;
  wire hit_ctrl = paddr == preload_pkg::OFS_CTRL;
  wire hit_status = paddr == preload_pkg::OFS_STATUS;
  wire hit_arch = paddr == preload_pkg::OFS_ARCH;
  wire hit_sig_lo = paddr == preload_pkg::OFS_SIG_LO;
  wire hit_sig_hi = paddr == preload_pkg::OFS_SIG_HI;
  wire hit_addr = paddr == preload_pkg::OFS_ARR_ADDR;
  wire hit_data = paddr == preload_pkg::OFS_ARR_DATA;
  wire mapped = hit_ctrl | hit_status | hit_arch | hit_sig_lo |
                hit_sig_hi | hit_addr | hit_data;
  wire erasing = er_state_r == preload_pkg::ER_WALK;
  wire prog_ok = ~secured_r & ~erasing;
  wire erase_go = wr_fire & hit_ctrl & ~erasing &
                  pwdata[preload_pkg::CTRL_ERASE_BIT];
  wire secure_go = wr_fire & hit_ctrl & prog_ok & ~erase_go &
                   pwdata[preload_pkg::CTRL_SECURE_BIT];
  wire arch_wr = wr_fire & hit_arch & prog_ok;
  wire sig_lo_wr = wr_fire & hit_sig_lo & prog_ok;
  wire sig_hi_wr = wr_fire & hit_sig_hi & prog_ok;
  wire addr_wr = wr_fire & hit_addr;
  wire data_wr = wr_fire & hit_data & prog_ok;
  wire er_last = erasing & (er_addr_r == AW'(DEPTH - 1));

  // ---------------------------------------------------------------
  // Array store and bulk erase walk
  // ---------------------------------------------------------------
  logic [W-1:0] mem_rdata;
  wire mem_we = erasing | data_wr;
  wire [AW-1:0] mem_waddr = erasing ? er_addr_r : arr_addr_r;
  wire [W-1:0] mem_wdata = erasing ? '0 : pwdata;

  array_mem #(.WIDTH(W), .DEPTH(DEPTH), .AW(AW)) u_array (
    .clk(pclk),
    .rst_n(presetn),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr(arr_addr_r),
    .rdata(mem_rdata)
  );

  always_comb begin
    er_state_nxt = er_state_r;
    er_addr_nxt = er_addr_r;
    unique case (er_state_r)
      preload_pkg::ER_IDLE: begin
        if (erase_go) begin
          er_state_nxt = preload_pkg::ER_WALK;
          er_addr_nxt = '0;
        end
      end
      preload_pkg::ER_WALK: begin
        er_addr_nxt = er_addr_r + AW'(1);
        if (er_last) begin
          er_state_nxt = preload_pkg::ER_IDLE;
        end
      end
      default: begin
        er_state_nxt = preload_pkg::ER_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Configuration, signature and security next values
  // ---------------------------------------------------------------
  always_comb begin
    arch_nxt = arch_r;
    sig_nxt = sig_r;
    secured_nxt = secured_r;
    arr_addr_nxt = arr_addr_r;
    if (erase_go) begin
      arch_nxt.registered = preload_pkg::REG_MASK_RST;
      arch_nxt.polarity = preload_pkg::POL_RST;
      sig_nxt = preload_pkg::SIG_RST;
    end
    if (arch_wr) begin
      arch_nxt.registered = pwdata[preload_pkg::ARCH_REG_LSB +: N];
      arch_nxt.polarity = pwdata[preload_pkg::ARCH_POL_LSB +: N];
    end
    if (sig_lo_wr) begin
      sig_nxt[W-1:0] = pwdata;
    end
    if (sig_hi_wr) begin
      sig_nxt[2*W-1:W] = pwdata;
    end
    if (addr_wr) begin
      arr_addr_nxt = pwdata[AW-1:0];
    end
    if (secure_go) begin
      secured_nxt = 1'b1;
    end
    if (er_last) begin
      secured_nxt = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arch_r <= '{polarity: preload_pkg::POL_RST,
                  registered: preload_pkg::REG_MASK_RST};
      sig_r <= preload_pkg::SIG_RST;
      secured_r <= 1'b0;
      arr_addr_r <= '0;
      er_state_r <= preload_pkg::ER_IDLE;
      er_addr_r <= '0;
    end else begin
      arch_r <= arch_nxt;
      sig_r <= sig_nxt;
      secured_r <= secured_nxt;
      arr_addr_r <= arr_addr_nxt;
      er_state_r <= er_state_nxt;
      er_addr_r <= er_addr_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Read mux and APB answer
  // ---------------------------------------------------------------
  logic [W-1:0] status_word;
  logic [W-1:0] arch_word;
  logic [W-1:0] rd_word;

  always_comb begin
    status_word = '0;
    status_word[preload_pkg::STAT_SECURED_BIT] = secured_r;
    status_word[preload_pkg::STAT_PRELOAD_BIT] = preload_active;
    status_word[preload_pkg::STAT_ERASING_BIT] = erasing;
    arch_word = '0;
    arch_word[preload_pkg::ARCH_REG_LSB +: N] = arch_r.registered;
    arch_word[preload_pkg::ARCH_POL_LSB +: N] = arch_r.polarity;
  end

  assign rd_word =
    hit_status ? status_word :
    hit_arch ? (secured_r ? '0 : arch_word) :
    hit_sig_lo ? sig_r[W-1:0] :
    hit_sig_hi ? sig_r[2*W-1:W] :
    hit_addr ? W'(arr_addr_r) :
    hit_data ? (secured_r ? '0 : mem_rdata) :
    '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= take;
      pslverr <= take & ~mapped;
      if (take) begin
        prdata <= pwrite ? '0 : rd_word;
      end
    end
  end

  // ---------------------------------------------------------------
  // Macrocell registers and preload chain
  // ---------------------------------------------------------------
  logic [N-1:0] cell_q_r;
  logic [N-1:0] cell_q_nxt;
  logic [N-1:0] shift_q;
  logic shift_carry;
  logic [N-1:0] func_d;

  // Polarity acts ahead of the register; signature plays no part
  assign func_d = mc_logic_in ^ arch_r.polarity;

  always_comb begin
    shift_q = cell_q_r;
    shift_carry = sin_bit;
    for (int i = 0; i < N; i++) begin
      if (arch_r.registered[i]) begin
        shift_q[i] = shift_carry;
        shift_carry = cell_q_r[i];
      end
    end
  end

  always_comb begin
    cell_q_nxt = cell_q_r;
    if (shift_edge) begin
      cell_q_nxt = shift_q;
    end else if (func_edge) begin
      cell_q_nxt = (arch_r.registered & func_d) |
                   (~arch_r.registered & cell_q_r);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cell_q_r <= preload_pkg::CELL_RST;
    end else begin
      cell_q_r <= cell_q_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Pin drivers
  // ---------------------------------------------------------------
  // Highest registered cell drives the open drain; no OE gating
  wire sdo_low = preload_active & (|arch_r.registered) &
                 ~shift_carry;
  wire [N-1:0] pin_nxt = (arch_r.registered & ~cell_q_r) |
                         (~arch_r.registered & func_d);
  wire [N-1:0] pin_oe_nxt = (arch_r.registered & {N{~oe_pin_n}}) |
                            ~arch_r.registered;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_preload_out_o <= 1'b0;
      serial_preload_out_oe <= 1'b0;
      mc_pin_o <= '0;
      mc_pin_oe <= '0;
    end else begin
      serial_preload_out_o <= 1'b0;
      serial_preload_out_oe <= sdo_low;
      mc_pin_o <= pin_nxt;
      mc_pin_oe <= pin_oe_nxt;
    end
  end

endmodule : preload_security
`default_nettype wire

// ### verif/preload_security_checker.sv
/*
  Port checker for the preload and security block.
  Assumes the bind at the foot attaches it to every instance.
*/
`timescale 1ns/1ps
`default_nettype none
module preload_security_checker (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB address
  input wire logic [31:0] prdata, // APB read data
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic preload_mode_hv_pin, // Preload entry
  input wire logic preload_shift_clock, // Shift clock
  input wire logic func_clock_pin, // Function clock
  input wire logic [7:0] mc_logic_in, // Sum terms
  input wire logic serial_preload_out_o, // Serial out level
  input wire logic serial_preload_out_oe, // Serial out enable
  input wire logic [7:0] mc_pin_o // Cell pins
);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_SDO_LOW:
    assert property (serial_preload_out_o == 1'b0)
      else $error("serial out level driven high");
  AST_SDO_IDLE:
    assert property ((!preload_mode_hv_pin) [*8] |-> !serial_preload_out_oe)
      else $error("serial out pulled low outside preload");
  AST_ONE_WAIT:
    assert property (psel && penable && !pready |=> pready)
      else $error("ready not in second access cycle");
  AST_READY_PULSE:
    assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
  AST_ERR_READY:
    assert property (pslverr |-> pready)
      else $error("error without ready");
  AST_UNMAPPED:
    assert property (pready && paddr > 8'h18 |-> pslverr)
      else $error("unmapped address not refused");
  AST_MAPPED:
    assert property (pready && paddr <= 8'h18 && paddr[1:0] == 2'b00
      |-> !pslverr) else $error("mapped address refused");
  AST_RD_ZERO:
    assert property (pslverr && !pwrite |-> prdata == 32'h0)
      else $error("refused read data not zero");
  AST_IDLE_HOLD:
    assert property ((!preload_mode_hv_pin && !func_clock_pin && !psel
      && $stable(mc_logic_in)) [*8] |-> $stable(mc_pin_o))
      else $error("pins moved without function clock");
  AST_PRELOAD_HOLD:
    assert property ((preload_mode_hv_pin && !preload_shift_clock && !psel
      && $stable(mc_logic_in)) [*8] |-> $stable(mc_pin_o))
      else $error("pins moved in preload without shift");
endmodule : preload_security_checker

bind preload_security preload_security_checker chk (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
  .preload_mode_hv_pin, .preload_shift_clock, .func_clock_pin,
  .mc_logic_in, .serial_preload_out_o, .serial_preload_out_oe, .mc_pin_o);
`default_nettype wire

// ### verif/preload_tester.sv
/*
  Model of the external tester on the preload pins.
  Assumes the bench calls its tasks; serial out has a pull-up.
*/
`timescale 1ns/1ps
`default_nettype none
module preload_tester (
  input wire logic pclk, // Clock
  input wire logic serial_preload_out_o, // Drain level
  input wire logic serial_preload_out_oe, // Drain enable
  output logic preload_mode_hv_pin, // Preload entry
  output logic serial_preload_in, // Serial data
  output logic preload_shift_clock // Shift clock
);
  // ---------------------------------------------------------------
  // Pin drive
  // ---------------------------------------------------------------
  wire logic sdo;
  assign sdo = serial_preload_out_oe ? serial_preload_out_o : 1'b1;

  initial begin
    preload_mode_hv_pin = 1'b0;
    serial_preload_in = 1'b0;
    preload_shift_clock = 1'b0;
  end

  task set_mode(input logic m);
    @(posedge pclk);
    preload_mode_hv_pin <= m;
    repeat (40) @(posedge pclk);
  endtask : set_mode

  // One bit per stage; 1 us high and low
  task shift(input logic b, output logic o);
    o = sdo;
    @(posedge pclk);
    serial_preload_in <= b;
    repeat (40) @(posedge pclk);
    preload_shift_clock <= 1'b1;
    repeat (40) @(posedge pclk);
    preload_shift_clock <= 1'b0;
  endtask : shift
endmodule : preload_tester
`default_nettype wire

// ### verif/tb_macrocell_preload_scan_and_security.sv
/*
  Self-checking bench for the preload and security block.
  Assumes the checker is bound and the tester model drives preload pins.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_macrocell_preload_scan_and_security;
  typedef struct packed {
    logic w;
    logic [7:0] a;
    logic [31:0] d;
    logic e;
  } row_s;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, mc_logic_in, mc_pin_o, mc_pin_oe, q;
  logic [31:0] pwdata, prdata, rd;
  logic func_clock_pin, output_enable_n_pin, serial_preload_out_o;
  logic serial_preload_out_oe, preload_mode_hv_pin, serial_preload_in;
  logic preload_shift_clock, er, o;
  int miscompares, compares;
  row_s rows [13] = '{'{0, 8'h04, 0, 0}, '{0, 8'h08, 0, 0},
    '{0, 8'h0c, 0, 0}, '{0, 8'h10, 0, 0}, '{1, 8'h0c, 32'hcafe0123, 0},
    '{1, 8'h10, 32'h89abcdef, 0}, '{0, 8'h0c, 32'hcafe0123, 0},
    '{0, 8'h10, 32'h89abcdef, 0}, '{1, 8'h14, 32'h3, 0},
    '{1, 8'h18, 32'h5a5a0f0f, 0}, '{0, 8'h18, 32'h5a5a0f0f, 0},
    '{0, 8'h1c, 0, 1}, '{1, 8'h20, 32'hffffffff, 1}};

  preload_security uut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .preload_mode_hv_pin,
    .serial_preload_in, .preload_shift_clock, .func_clock_pin,
    .output_enable_n_pin, .mc_logic_in, .serial_preload_out_o,
    .serial_preload_out_oe, .mc_pin_o, .mc_pin_oe);
  preload_tester tst (.pclk, .serial_preload_out_o, .serial_preload_out_oe,
    .preload_mode_hv_pin, .serial_preload_in, .preload_shift_clock);

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task chk(input logic [31:0] g, input logic [31:0] x, input string m);
    compares++;
    if (g !== x) begin
      miscompares++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, g, x);
    end
  endtask : chk

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rdc(input logic [7:0] a, input logic [31:0] x, input string m);
    apb(1'b0, a, 32'h0);
    chk(rd, x, m);
  endtask : rdc

  task fclk();
    @(posedge pclk);
    func_clock_pin <= 1'b1;
    repeat (40) @(posedge pclk);
    func_clock_pin <= 1'b0;
    repeat (40) @(posedge pclk);
  endtask : fclk

  task give_verdict();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  // ---------------------------------------------------------------
  // Stimulus
  // ---------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    $display("wrong value at %0t: run hung", $time);
    give_verdict();
  end

  initial begin
    {psel, penable, pwrite, presetn, func_clock_pin} = 5'h0;
    {paddr, pwdata, mc_logic_in, output_enable_n_pin} = 49'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk(rd, rows[i].d, "row data");
      chk({31'h0, er}, {31'h0, rows[i].e}, "row error");
    end
    $display("test registers done");
    apb(1'b1, 8'h08, 32'h000000ff);
    repeat (1800) @(posedge pclk);
    tst.set_mode(1'b1);
    rdc(8'h04, 32'h2, "preload status");
    output_enable_n_pin <= 1'b1;
    q = 8'hb2;
    for (int i = 7; i >= 0; i--) begin
      tst.shift(q[i], o);
      chk({31'h0, o}, 32'h0, "first out");
    end
    mc_logic_in <= 8'h0f;
    fclk();
    chk({24'h0, mc_pin_o}, 32'h4d, "pins inverted");
    chk({24'h0, mc_pin_oe}, 32'h0, "pins disabled");
    for (int i = 0; i < 8; i++) begin
      tst.shift(tst.sdo, o);
      q = {q[6:0], o};
    end
    chk({24'h0, q}, 32'hb2, "state readout");
    $display("test preload done");
    tst.set_mode(1'b0);
    tst.shift(1'b1, o);
    chk({24'h0, mc_pin_o}, 32'h4d, "shift ignored");
    fclk();
    chk({24'h0, mc_pin_o}, 32'hf0, "normal load");
    apb(1'b1, 8'h08, 32'h0000000a);
    tst.set_mode(1'b1);
    tst.shift(1'b1, q[1]);
    tst.shift(1'b0, q[0]);
    chk({30'h0, q[1:0]}, 32'h3, "short chain out");
    chk({30'h0, mc_pin_o[3], mc_pin_o[1]}, 32'h1, "short chain");
    tst.set_mode(1'b0);
    $display("test chain done");
    apb(1'b1, 8'h00, 32'h2);
    rdc(8'h04, 32'h1, "secured");
    rdc(8'h08, 32'h0, "arch hidden");
    rdc(8'h18, 32'h0, "array hidden");
    apb(1'b1, 8'h18, 32'h1);
    rdc(8'h0c, 32'hcafe0123, "signature open");
    apb(1'b1, 8'h00, 32'h1);
    rdc(8'h04, 32'h5, "erasing");
    repeat (20) @(posedge pclk);
    rdc(8'h04, 32'h0, "erased status");
    rdc(8'h08, 32'h0, "erased arch");
    rdc(8'h10, 32'h0, "erased signature");
    rdc(8'h18, 32'h0, "erased array");
    apb(1'b1, 8'h08, 32'h000000ff);
    rdc(8'h08, 32'hff, "reprogram");
    $display("test security done");
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rdc(8'h04, 32'h0, "reset status");
    chk({24'h0, mc_pin_o}, 32'h0f, "reset pins");
    $display("test reset done");
    give_verdict();
  end
endmodule : tb_macrocell_preload_scan_and_security
`default_nettype wire
